// ===== hdl/mtc_classifier.sv
`timescale 1ns/1ps
module mtc_classifier
    import mtc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // timing sources and slicer
    input  wire logic       os_tick_in,          // oversampling tick, 128 per chip
    input  wire logic       bit_tick_in,         // mainscaler tick, one per bit
    input  wire logic       edge_in,             // slicer edge pulse
    input  wire logic       search_start_in,     // start of wakeup search pulse
    // wakeup decision inputs
    input  wire logic       wakeup_positive_in,  // positive decision reached
    input  wire logic       detector_fail_in,    // any detector failing
    // configuration
    input  wire logic [1:0] chip_error_limit_sel,
    input  wire logic [1:0] coding_restriction_sel,
    input  wire logic [2:0] block_error_limit_sel,
    input  wire logic [1:0] baud_observe_length_sel,
    input  wire logic [5:0] wakeup_timeout_count,
    input  wire logic [1:0] wakeup_timeout_prescale,
    // results
    output logic            chip_valid_out,
    output logic            chip_error_out,
    output logic            code_valid_out,
    output logic            code_error_out,
    output logic            baud_valid_out,
    output logic            baud_error_out,
    output logic            wakeup_expired_out,  // one-cycle pulse
    output logic            wakeup_fail_out
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic       rst_meta_ff;      // first synchroniser stage
    logic       rst_n_ff;         // design-wide reset copy

    // two flops so release never lands near an edge
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // interval measurement
    // ------------------------------------------------------------
    logic [IV_W-1:0]   iv_cnt_ff;     // os ticks since last edge
    logic              is_short;      // interval below 1.5 chips
    logic signed [IV_W:0] iv_err;     // timing error, signed
    logic [IV_W-1:0]   iv_abs;        // absolute error
    logic              armed;         // an interval is being timed
    logic              timeout;       // interval passed 3.5 chips
    logic              eval;          // interval closed while checking
    logic              chip_bad;      // closed interval out of tolerance
    mtc_chip_t         ct_state_ff;
    mtc_chip_t         nxt_ct_state;

    // compare against one or two chips by length
    always_comb begin
        is_short = iv_cnt_ff < LONG_SPLIT;
        iv_err   = $signed({1'b0, iv_cnt_ff})
                 - $signed({1'b0, (is_short ? CHIP_OSR : TWO_CHIPS)});
        iv_abs   = iv_err[IV_W] ? IV_W'(-iv_err) : iv_err[IV_W-1:0];
    end

    assign armed    = (ct_state_ff != CT_IDLE) && (ct_state_ff != CT_RELOCK);
    assign timeout  = armed && os_tick_in && !edge_in
                    && (iv_cnt_ff == CHIP_TIMEOUT - 10'h001);
    assign eval     = edge_in && (ct_state_ff == CT_CHECK);
    assign chip_bad = eval && (iv_abs >= CHIP_LIMIT[chip_error_limit_sel]);

    // counter stops at the timeout so it fires only once per gap
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            iv_cnt_ff <= '0;
        end else if (search_start_in || edge_in) begin
            iv_cnt_ff <= '0;
        end else if (os_tick_in && iv_cnt_ff != CHIP_TIMEOUT) begin
            iv_cnt_ff <= iv_cnt_ff + 10'h001;
        end
    end

    // ------------------------------------------------------------
    // chip timing verifier
    // ------------------------------------------------------------
    logic chip_last_bad_ff;   // result of the latest interval check

    always_comb begin
        nxt_ct_state = ct_state_ff;
        case (ct_state_ff)
            CT_IDLE: begin
                if (edge_in) nxt_ct_state = CT_SYNC;
            end
            CT_SYNC: begin
                if (edge_in) nxt_ct_state = CT_CHECK;
                else if (timeout) nxt_ct_state = CT_IDLE;
            end
            CT_CHECK: begin
                // a bad interval alone never moves the state
                if (timeout) nxt_ct_state = CT_RELOCK;
            end
            CT_RELOCK: begin
                if (edge_in) nxt_ct_state = CT_RELOCK_1;
            end
            CT_RELOCK_1: begin
                if (edge_in) nxt_ct_state = CT_CHECK;
                else if (timeout) nxt_ct_state = CT_RELOCK;
            end
            default: nxt_ct_state = CT_IDLE;
        endcase
        if (search_start_in) nxt_ct_state = CT_IDLE;
    end

    // state and last check result
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ct_state_ff      <= CT_IDLE;
            chip_last_bad_ff <= 1'b0;
        end else begin
            ct_state_ff <= nxt_ct_state;
            if (search_start_in || nxt_ct_state != CT_CHECK) begin
                chip_last_bad_ff <= 1'b0;
            end else if (eval) begin
                chip_last_bad_ff <= chip_bad;
            end
        end
    end

    // registered chip outputs
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            chip_valid_out <= 1'b0;
            chip_error_out <= 1'b0;
        end else begin
            chip_valid_out <= (nxt_ct_state != CT_IDLE) && (nxt_ct_state != CT_SYNC);
            chip_error_out <= (nxt_ct_state == CT_RELOCK) || (nxt_ct_state == CT_RELOCK_1)
                            || (nxt_ct_state == CT_CHECK && eval ? chip_bad
                                : nxt_ct_state == CT_CHECK && chip_last_bad_ff);
        end
    end

    // ------------------------------------------------------------
    // code checker
    // ------------------------------------------------------------
    mtc_code_t cc_state_ff;
    mtc_code_t nxt_cc_state;
    logic      cc_restrict;   // any coding restriction active
    logic      cc_viol;       // closed interval breaks the coding

    // selection is assumed steady while running; a change can give
    // a false error now or later
    assign cc_restrict = coding_restriction_sel != 2'b00;

    always_comb begin
        cc_viol = 1'b0;
        if (coding_restriction_sel == 2'b01 && !is_short) cc_viol = 1'b1;
        if (coding_restriction_sel == 2'b10 && is_short)  cc_viol = 1'b1;
        // after a long one, a lone short before a long is illegal
        if (cc_restrict && cc_state_ff == CC_HALF && !is_short) cc_viol = 1'b1;
    end

    always_comb begin
        nxt_cc_state = cc_state_ff;
        case (cc_state_ff)
            CC_IDLE: begin
                if (ct_state_ff == CT_CHECK) nxt_cc_state = CC_START;
            end
            CC_START: begin
                // shorts stay unclassified until the first long
                if (eval && cc_restrict && !is_short) nxt_cc_state = CC_PAIRED;
            end
            CC_PAIRED: begin
                if (eval && cc_restrict && is_short) nxt_cc_state = CC_HALF;
            end
            CC_HALF: begin
                if (eval && is_short) nxt_cc_state = CC_PAIRED;
            end
            CC_RELOCK: begin
                if (eval && !chip_bad) nxt_cc_state = CC_START;
            end
            default: nxt_cc_state = CC_IDLE;
        endcase
        // a bad chip counts even in the cycle the checker leaves idle
        if (cc_state_ff != CC_RELOCK) begin
            if (chip_bad || (eval && cc_viol && cc_state_ff != CC_IDLE)) begin
                nxt_cc_state = CC_RELOCK;
            end
        end
        if (timeout && cc_state_ff != CC_IDLE) nxt_cc_state = CC_RELOCK;
        if (search_start_in) nxt_cc_state = CC_IDLE;
    end

    // state with its outputs taken straight from the next state
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cc_state_ff    <= CC_IDLE;
            code_valid_out <= 1'b0;
            code_error_out <= 1'b0;
        end else begin
            cc_state_ff    <= nxt_cc_state;
            code_valid_out <= nxt_cc_state != CC_IDLE;
            code_error_out <= nxt_cc_state == CC_RELOCK;
        end
    end

    // ------------------------------------------------------------
    // baud-rate checker
    // ------------------------------------------------------------
    mtc_baud_t         br_state_ff;
    mtc_baud_t         nxt_br_state;
    logic signed [15:0] br_sum_ff;     // undivided error sum of the block
    logic [4:0]        br_chips_ff;    // chips counted in the block
    logic [2:0]        br_good_ff;     // good blocks in a row
    logic signed [15:0] br_sum_new;
    logic [4:0]        br_chips_new;
    logic [15:0]       br_abs;
    logic              br_end;         // interval closes a block
    logic              br_pass;        // block sum within limit
    logic [2:0]        br_need;        // blocks for a full observation
    logic              br_abort;       // timeout or bad chip

    always_comb begin
        br_sum_new   = br_sum_ff + 16'(iv_err);
        br_chips_new = br_chips_ff + (is_short ? 5'h01 : 5'h02);
        br_abs       = br_sum_new[15] ? 16'(-br_sum_new) : br_sum_new;
        br_end       = eval && br_chips_new >= BLOCK_CHIPS;
        br_pass      = br_abs < BLOCK_LIMIT[block_error_limit_sel];
        br_need      = {1'b0, baud_observe_length_sel} + 3'h1;
        br_abort     = timeout || chip_bad;
    end

    always_comb begin
        nxt_br_state = br_state_ff;
        case (br_state_ff)
            BR_IDLE: begin
                // first block opens once the verifier has locked
                if (ct_state_ff == CT_CHECK) nxt_br_state = BR_RUN;
            end
            BR_RUN, BR_ERR: begin
                if (br_end && !br_pass) nxt_br_state = BR_ERR;
                else if (br_end && br_good_ff + 3'h1 >= br_need) nxt_br_state = BR_OK;
                else if (br_end) nxt_br_state = BR_RUN;
            end
            BR_OK: begin
                if (br_end && !br_pass) nxt_br_state = BR_ERR;
            end
            default: nxt_br_state = BR_IDLE;
        endcase
        if (br_abort && br_state_ff != BR_IDLE) nxt_br_state = BR_IDLE;
        if (search_start_in) nxt_br_state = BR_IDLE;
    end

    // state and block accumulators
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            br_state_ff <= BR_IDLE;
            br_sum_ff   <= '0;
            br_chips_ff <= '0;
            br_good_ff  <= '0;
        end else begin
            br_state_ff <= nxt_br_state;
            if (nxt_br_state == BR_IDLE || br_state_ff == BR_IDLE) begin
                br_sum_ff   <= '0;
                br_chips_ff <= '0;
                br_good_ff  <= '0;
            end else if (br_end) begin
                // overshoot chip restarts the next block at zero
                br_sum_ff   <= '0;
                br_chips_ff <= '0;
                br_good_ff  <= !br_pass ? 3'h0
                             : (br_good_ff + 3'h1 >= br_need) ? br_need
                             : br_good_ff + 3'h1;
            end else if (eval) begin
                br_sum_ff   <= br_sum_new;
                br_chips_ff <= br_chips_new;
            end
        end
    end

    // registered baud outputs
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            baud_valid_out <= 1'b0;
            baud_error_out <= 1'b0;
        end else begin
            baud_valid_out <= nxt_br_state == BR_OK || nxt_br_state == BR_ERR;
            baud_error_out <= nxt_br_state == BR_ERR;
        end
    end

    // ------------------------------------------------------------
    // wakeup search timer
    // ------------------------------------------------------------
    logic [6:0] wt_presc_ff;   // bit ticks within one unit
    logic [5:0] wt_count_ff;   // units elapsed
    logic       wt_done_ff;    // expired or a positive result seen
    logic       wt_enabled;
    logic       wt_unit_end;
    logic       wt_expire;

    assign wt_enabled  = wakeup_timeout_count != 6'h00;
    assign wt_unit_end = bit_tick_in
                       && (wt_presc_ff == PRESC_UNIT[wakeup_timeout_prescale] - 7'h01);
    // no truncation gives zero to one bit short, never long
    assign wt_expire   = wt_enabled && !wt_done_ff && !search_start_in && wt_unit_end
                       && (wt_count_ff + 6'h01 == wakeup_timeout_count);

    // prescaler counts mainscaler ticks, timer counts units
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wt_presc_ff <= '0;
            wt_count_ff <= '0;
            wt_done_ff  <= 1'b0;
        end else if (search_start_in) begin
            wt_presc_ff <= '0;
            wt_count_ff <= '0;
            wt_done_ff  <= 1'b0;
        end else begin
            if (wt_expire || wakeup_positive_in) wt_done_ff <= 1'b1;
            if (wt_unit_end) begin
                wt_presc_ff <= '0;
                wt_count_ff <= wt_count_ff + 6'h01;
            end else if (bit_tick_in) begin
                wt_presc_ff <= wt_presc_ff + 7'h01;
            end
        end
    end

    // negative result: expiry when enabled, any failure when not
    always_ff @(posedge clk_in or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            wakeup_expired_out <= 1'b0;
            wakeup_fail_out    <= 1'b0;
        end else begin
            wakeup_expired_out <= wt_expire;
            if (wt_expire || (!wt_enabled && detector_fail_in && !search_start_in)) begin
                wakeup_fail_out <= 1'b1;
            end else if (search_start_in) begin
                wakeup_fail_out <= 1'b0;
            end
        end
    end

endmodule // mtc_classifier

// ===== hdl/mtc_pkg.sv
// How it works
// - two edges lock chip timing, checking begins
// - last interval check is chip error
// - timeout flags error, relock on two edges
// - single bad interval keeps chip state
// - bad chip interval always errors code checker
// - code timeout above 3.5 chip widths
// - code error from state, violations relock
// - shorts unclassified until long, then paired
// - baud blocks of 8 bits from sync
// - sum errors, compare with 3-bit limit
// - observation 8, 16, 24 or 32 bits
// - baud invalid until first block, error fast
// - keep checking per block, error until pass
// - longer observation: not valid until full run
// - timeout or bad chip restarts baud checker
// - timer forces fail, else fail passes through
// - timer is prescaler plus count on bit ticks
// - timeout is count times unit, zero infinite
// - timeout short by up to one bit
// - four prescaler units: 2, 4, 16, 64 bits
// - 128x oversampling, split at 1.5 chips
// - chip error limit 16, 24, 32 or 48
// - search start resets every checker and timer
package mtc_pkg;

    // ------------------------------------------------------------
    // interval measurement, oversampling counts
    // ------------------------------------------------------------
    localparam int unsigned IV_W          = 10;
    localparam logic [9:0]  CHIP_OSR      = 10'h080;  // one chip, 128 counts
    localparam logic [9:0]  LONG_SPLIT    = 10'h0C0;  // 1.5 chips
    localparam logic [9:0]  TWO_CHIPS     = 10'h100;
    localparam logic [9:0]  CHIP_TIMEOUT  = 10'h1C0;  // 3.5 chips
    localparam logic [9:0]  CHIP_LIMIT [4] = '{10'h010, 10'h018, 10'h020, 10'h030};

    // ------------------------------------------------------------
    // baud-rate checker
    // ------------------------------------------------------------
    localparam logic [4:0]  BLOCK_CHIPS   = 5'h10;    // 8 bits, 16 chips
    localparam logic [15:0] BLOCK_LIMIT [8] = '{16'h0010, 16'h0018, 16'h0020, 16'h0030,
                                                16'h0040, 16'h0060, 16'h0080, 16'h00C0};

    // ------------------------------------------------------------
    // wakeup timer, prescaler units counted in bit ticks
    // ------------------------------------------------------------
    localparam logic [6:0]  PRESC_UNIT [4] = '{7'h02, 7'h04, 7'h10, 7'h40};

    // ------------------------------------------------------------
    // state machines, one-hot
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CT_IDLE     = 5'h01,
        CT_SYNC     = 5'h02,
        CT_CHECK    = 5'h04,
        CT_RELOCK   = 5'h08,
        CT_RELOCK_1 = 5'h10
    } mtc_chip_t;

    typedef enum logic [4:0] {
        CC_IDLE   = 5'h01,
        CC_START  = 5'h02,
        CC_PAIRED = 5'h04,
        CC_HALF   = 5'h08,
        CC_RELOCK = 5'h10
    } mtc_code_t;

    typedef enum logic [3:0] {
        BR_IDLE = 4'h1,
        BR_RUN  = 4'h2,
        BR_OK   = 4'h4,
        BR_ERR  = 4'h8
    } mtc_baud_t;

endpackage : mtc_pkg

// ===== dv/mtc_classifier_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the timing classifier
// ------------------------------------------------------------
module mtc_classifier_props (
    input wire logic       clk_in,
    input wire logic       reset_n_in,
    input wire logic       bit_tick_in,
    input wire logic       edge_in,
    input wire logic       search_start_in,
    input wire logic [5:0] wakeup_timeout_count,
    input wire logic       chip_valid_out,
    input wire logic       chip_error_out,
    input wire logic       code_valid_out,
    input wire logic       code_error_out,
    input wire logic       baud_valid_out,
    input wire logic       baud_error_out,
    input wire logic       wakeup_expired_out,
    input wire logic       wakeup_fail_out
);
    // one clock domain, so clock and disable are given once
    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_sync_on_edge: assert property ($rose(chip_valid_out) |-> $past(edge_in))
        else $error("chip valid rose without an edge");
    a_chip_err_valid: assert property (chip_error_out |-> chip_valid_out)
        else $error("chip error while not valid");
    a_bad_chip_code: assert property ($rose(chip_error_out) |-> code_error_out)
        else $error("chip error without code error");
    a_code_err_valid: assert property (code_error_out |-> code_valid_out)
        else $error("code error while not valid");
    a_baud_drop_bad: assert property ($rose(chip_error_out) |-> !baud_valid_out)
        else $error("baud stayed valid after chip error");
    a_baud_err_valid: assert property (baud_error_out |-> baud_valid_out)
        else $error("baud error while not valid");
    a_search_clears: assert property (search_start_in |=>
        !chip_valid_out && !code_valid_out && !baud_valid_out)
        else $error("search start left a checker valid");
    a_expiry_single: assert property (wakeup_expired_out |=> !wakeup_expired_out)
        else $error("expiry pulse longer than one cycle");
    a_expiry_on_tick: assert property (wakeup_expired_out |-> $past(bit_tick_in))
        else $error("expiry not after a bit tick");
    a_expiry_fails: assert property (wakeup_expired_out |-> ##[0:1] wakeup_fail_out)
        else $error("expiry did not set fail");
    a_zero_no_expiry: assert property ($stable(wakeup_timeout_count) &&
        wakeup_timeout_count == 6'h00 |-> !wakeup_expired_out)
        else $error("expiry with count zero");
    a_fail_sticky: assert property (wakeup_fail_out && !search_start_in |=> wakeup_fail_out)
        else $error("fail dropped without search start");
endmodule // mtc_classifier_props

bind mtc_classifier mtc_classifier_props mtc_classifier_props_inst (
    .clk_in, .reset_n_in, .bit_tick_in, .edge_in, .search_start_in, .wakeup_timeout_count,
    .chip_valid_out, .chip_error_out, .code_valid_out, .code_error_out, .baud_valid_out,
    .baud_error_out, .wakeup_expired_out, .wakeup_fail_out);

// ===== dv/mtc_slicer_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// slicer and baud generator stand-in
// ------------------------------------------------------------
module mtc_slicer_model (
    input  wire logic clk_in,
    output logic      os_tick_out,
    output logic      bit_tick_out,
    output logic      edge_out
);
    logic [7:0] bit_cnt_ff = 8'h00;  // 256 oversampling ticks per bit

    // one oversampling tick per clock keeps gaps equal to cycle counts
    assign os_tick_out  = 1'b1;
    assign bit_tick_out = (bit_cnt_ff == 8'hFF);

    // free running bit divider, two chips of 128 ticks each
    always_ff @(posedge clk_in) begin
        bit_cnt_ff <= bit_cnt_ff + 8'h01;
    end

    initial edge_out = 1'b0;

    // edge after gap cycles; the interval seen is gap ticks
    task automatic send_edge(input int gap);
        repeat (gap) @(posedge clk_in);
        #1 edge_out = 1'b1;
        @(posedge clk_in);
        #1 edge_out = 1'b0;
    endtask
endmodule // mtc_slicer_model

// ===== dv/mtc_classifier_test.sv
`timescale 1ns/1ps
module mtc_classifier_test;
    import mtc_pkg::*;
    logic       clk_in, reset_n_in, os_tick, bit_tick, edge_p, search_start;
    logic       wakeup_positive, detector_fail;
    logic [1:0] chip_sel, coding_sel, obs_sel, presc;
    logic [2:0] block_sel;
    logic [5:0] to_count;
    logic       chip_v, chip_e, code_v, code_e, baud_v, baud_e, expired, fail;
    int         n_mismatch = 0;
    int         n_tests    = 0;

    mtc_slicer_model mtc_slicer_model_inst (.clk_in(clk_in), .os_tick_out(os_tick),
        .bit_tick_out(bit_tick), .edge_out(edge_p));
    mtc_classifier mtc_classifier_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .os_tick_in(os_tick), .bit_tick_in(bit_tick), .edge_in(edge_p),
        .search_start_in(search_start), .wakeup_positive_in(wakeup_positive),
        .detector_fail_in(detector_fail), .chip_error_limit_sel(chip_sel),
        .coding_restriction_sel(coding_sel), .block_error_limit_sel(block_sel),
        .baud_observe_length_sel(obs_sel), .wakeup_timeout_count(to_count),
        .wakeup_timeout_prescale(presc), .chip_valid_out(chip_v), .chip_error_out(chip_e),
        .code_valid_out(code_v), .code_error_out(code_e), .baud_valid_out(baud_v),
        .baud_error_out(baud_e), .wakeup_expired_out(expired), .wakeup_fail_out(fail));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // inputs always move 1 ns after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic start_search();
        search_start = 1'b1;
        step(1);
        search_start = 1'b0;
        step(1);
    endtask

    // n edges spaced by the same gap, then let outputs settle
    task automatic gaps(input int n, input int gap);
        repeat (n) mtc_slicer_model_inst.send_edge(gap);
        step(2);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int cnt, u;
        reset_n_in = 1'b0; search_start = 1'b0; wakeup_positive = 1'b0; detector_fail = 1'b0;
        chip_sel = 2'h0; coding_sel = 2'h0; block_sel = 3'h7; obs_sel = 2'h1;
        to_count = 6'h00; presc = 2'h0;
        step(3);
        reset_n_in = 1'b1;
        step(3);
        chk("chip_valid", 1'b0, chip_v);
        start_search();
        gaps(1, 4);
        gaps(1, 127);
        chk("chip_valid", 1'b1, chip_v);
        chk("chip_error", 1'b0, chip_e);
        chk("code_valid", 1'b1, code_v);
        $display("test sync done");
        // two good blocks are needed when 16 bits are observed
        gaps(16, 127);
        chk("baud_valid", 1'b0, baud_v);
        gaps(16, 127);
        chk("baud_valid", 1'b1, baud_v);
        chk("baud_error", 1'b0, baud_e);
        // skew of 9 per chip passes each chip but not the block sum
        block_sel = 3'h0;
        gaps(16, 137);
        chk("chip_error", 1'b0, chip_e);
        chk("baud_error", 1'b1, baud_e);
        chk("baud_valid", 1'b1, baud_v);
        $display("test baud done");
        gaps(1, 199);
        chk("chip_error", 1'b1, chip_e);
        chk("chip_valid", 1'b1, chip_v);
        chk("code_error", 1'b1, code_e);
        chk("baud_valid", 1'b0, baud_v);
        gaps(1, 127);
        chk("chip_error", 1'b0, chip_e);
        step(460);
        chk("chip_error", 1'b1, chip_e);
        chk("code_error", 1'b1, code_e);
        gaps(1, 10);
        gaps(1, 127);
        chk("chip_error", 1'b0, chip_e);
        $display("test bad chip done");
        coding_sel = 2'h3;
        start_search();
        gaps(1, 4);
        gaps(1, 127);
        gaps(3, 127);
        chk("code_error", 1'b0, code_e);
        gaps(1, 255);
        gaps(2, 127);
        gaps(1, 255);
        chk("code_error", 1'b0, code_e);
        gaps(1, 127);
        gaps(1, 255);
        chk("code_error", 1'b1, code_e);
        // shorts only, then longs only: the other length is a violation
        for (int m = 1; m < 3; m++) begin
            coding_sel = m[1:0];
            start_search();
            gaps(1, 4);
            gaps(1, (m == 1) ? 127 : 255);
            gaps(1, (m == 1) ? 127 : 255);
            chk("code_error", 1'b0, code_e);
            gaps(1, (m == 1) ? 255 : 127);
            chk("code_error", 1'b1, code_e);
        end
        $display("test coding done");
        coding_sel = 2'h0;
        to_count = 6'h01;
        for (int p = 0; p < 4; p++) begin
            presc = p[1:0];
            u = int'(PRESC_UNIT[p]);
            start_search();
            cnt = 0;
            while (expired !== 1'b1 && cnt < 17000) begin
                step(1);
                cnt++;
            end
            if (cnt >= 17000) begin
                n_mismatch++;
                finish_test();
            end
            chk("expiry_early", 1'b1, cnt >= (u - 2) * 256);
            chk("expiry_late", 1'b1, cnt <= u * 256 + 4);
            step(2);
            chk("wakeup_fail", 1'b1, fail);
        end
        // shortest unit, so expiry would fall inside the wait below
        presc = 2'h0;
        start_search();
        wakeup_positive = 1'b1;
        step(1);
        wakeup_positive = 1'b0;
        step(700);
        chk("wakeup_fail", 1'b0, fail);
        to_count = 6'h00;
        start_search();
        step(700);
        chk("wakeup_fail", 1'b0, fail);
        detector_fail = 1'b1;
        step(3);
        chk("wakeup_fail", 1'b1, fail);
        detector_fail = 1'b0;
        start_search();
        chk("wakeup_fail", 1'b0, fail);
        $display("test timer done");
        finish_test();
    end
endmodule // mtc_classifier_test
